// *** common/clk_stop_regs.vh ***
`ifndef CLK_STOP_REGS_VH
`define CLK_STOP_REGS_VH
// Register byte addresses (one 32-bit word each)
`define ADDR_DRIVE_MODE 12'h014
`define ADDR_CONTROL 12'h018
`define ADDR_REQ_MAP 12'h020
`define ADDR_STATUS 12'h024
`define ADDR_CPU_CFG 12'h028
`define ADDR_PCI_CFG 12'h02C
// Reset values
`define RST_DRIVE_MODE 8'h00
`define RST_CONTROL 8'h18
`define RST_REQ_MAP 8'h44
`define RST_CPU_CFG 8'h07
`define RST_PCI_CFG 8'h00
// Field positions
`define BIT_SW_PCI_RUN 3
`define BIT_SRC_PD_MODE 3
`define BIT_MAP_B_PAIR5 6
`define BIT_MAP_B_PAIR3 5
`define BIT_MAP_B_PAIR1 4
`define BIT_MAP_A_PAIR4 2
`define BIT_MAP_A_PAIR2 1
`define BIT_MAP_A_PAIR0 0
// Timing
`define CLK_PERIOD_NS 4
`define STOP_DELAY_CYC 2
`define PARK_DELAY_CYC 4
`define LOCK_TIME_US 1800
`define TRI_RELEASE_US 300
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define LOCK_CYC (`LOCK_TIME_US * `CYC_PER_US)
`define TRI_REL_CYC (`TRI_RELEASE_US * `CYC_PER_US)
`endif

// *** rtl/level_filter.v ***
`timescale 1ns/100ps
// Two-stage synchroniser followed by a two-edge debounce compare
module level_filter #(
   parameter RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_arst_n,
   // Asynchronous level in, filtered level out
   input wire i_async,
   output reg o_level
);
   reg meta;
   reg sync;
   reg sync_d;

   // First stage feeds only the second
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta <= RESET_VAL;
         sync <= RESET_VAL;
         sync_d <= RESET_VAL;
         o_level <= RESET_VAL;
      end else begin
         meta <= i_async;
         sync <= meta;
         sync_d <= sync;
         // Level must match on two consecutive edges
         if (sync == sync_d)
            o_level <= sync_d;
      end
   end
endmodule // level_filter

// *** rtl/clock_output_stop_power_down_control.v ***
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`include "clk_stop_regs.vh"
module clock_output_stop_power_down_control #(
   parameter LOCK_CYCLES = `LOCK_CYC,
   parameter TRI_REL_CYCLES = `TRI_REL_CYC
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_arst_n,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // Sideband stop inputs
   input wire [1:0] i_src_clock_request_n,
   input wire i_cpu_clock_stop_n,
   input wire i_pci_clock_stop_n,
   input wire i_power_good_n,
   // Raw clocks from the synthesiser
   input wire i_diff_clock_complement,
   input wire i_pci_raw,
   // SRC pairs
   output reg [5:0] o_serial_ref_clock_true,
   output reg [5:0] o_serial_ref_clock_comp,
   output reg [5:0] o_src_true_oe,
   output reg [5:0] o_src_comp_oe,
   // CPU pairs
   output reg [2:0] o_cpu_clock_true,
   output reg [2:0] o_cpu_clock_comp,
   output reg [2:0] o_cpu_true_oe,
   output reg [2:0] o_cpu_comp_oe,
   // PCI clocks
   output reg o_pci_clk,
   output reg o_free_pci_clock,
   // Oscillator and PLL control
   output reg o_osc_enable,
   output reg o_clocks_stable
);
   localparam ST_WAIT_PG = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_PARK = 2'd2;
   localparam ST_DOWN = 2'd3;

   reg [7:0] drive_mode;
   reg [7:0] control;
   reg [7:0] req_map;
   reg [7:0] cpu_cfg;
   reg [7:0] pci_cfg;
   reg [1:0] state;
   reg [2:0] park_cnt;
   reg [31:0] lock_cnt;
   reg [31:0] tri_cnt;
   reg locked;
   reg tri_hold;
   reg [5:0] src_stopped;
   reg [2:0] cpu_stopped;
   reg pci_stopped;
   reg [1:0] cpu_wait;
   reg diff_d;
   reg pci_d;
   reg [31:0] next_rdata;
   wire [1:0] req_n;
   wire cpu_stop_n;
   wire pci_stop_n;
   wire pin_level;
   wire diff_fall;
   wire pci_fall;
   wire apb_access;
   wire pci_stop;
   wire [5:0] src_req;
   wire powered;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_req
         level_filter #(.RESET_VAL(1'b1)) u_req (
            .i_ref_clk(i_ref_clk),
            .i_arst_n(i_arst_n),
            .i_async(i_src_clock_request_n[g]),
            .o_level(req_n[g])
         );
      end
   endgenerate
   level_filter #(.RESET_VAL(1'b1)) u_cpu (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_async(i_cpu_clock_stop_n),
      .o_level(cpu_stop_n)
   );
   level_filter #(.RESET_VAL(1'b1)) u_pci (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_async(i_pci_clock_stop_n),
      .o_level(pci_stop_n)
   );
   level_filter #(.RESET_VAL(1'b1)) u_pd (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_async(i_power_good_n),
      .o_level(pin_level)
   );

   assign diff_fall = diff_d & ~i_diff_clock_complement;
   assign pci_fall = pci_d & ~i_pci_raw;
   assign apb_access = i_psel & i_penable & o_pready;
   // Stop on pin low OR software run bit clear
   assign pci_stop = ~pci_stop_n | ~control[`BIT_SW_PCI_RUN];
   // Odd pairs follow request B, even pairs request A
   // A request pin high asks for a stop; low lets the pair run
   assign src_req[0] = req_n[0] & req_map[`BIT_MAP_A_PAIR0];
   assign src_req[2] = req_n[0] & req_map[`BIT_MAP_A_PAIR2];
   assign src_req[4] = req_n[0] & req_map[`BIT_MAP_A_PAIR4];
   assign src_req[1] = req_n[1] & req_map[`BIT_MAP_B_PAIR1];
   assign src_req[3] = req_n[1] & req_map[`BIT_MAP_B_PAIR3];
   assign src_req[5] = req_n[1] & req_map[`BIT_MAP_B_PAIR5];
   assign powered = (state == ST_RUN) & locked;

   always @* begin
      next_rdata = 32'h00000000;
      case (i_paddr)
         `ADDR_DRIVE_MODE: next_rdata[7:0] = drive_mode;
         `ADDR_CONTROL: next_rdata[7:0] = control;
         `ADDR_REQ_MAP: next_rdata[7:0] = req_map;
         `ADDR_CPU_CFG: next_rdata[7:0] = cpu_cfg;
         `ADDR_PCI_CFG: next_rdata[7:0] = pci_cfg;
         `ADDR_STATUS: next_rdata[7:0] = {state, locked, tri_hold,
            pci_stopped, cpu_stopped != 3'h0, src_stopped != 6'h00,
            pin_level};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // APB: one wait state, slverr on unmapped address
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
         drive_mode <= `RST_DRIVE_MODE;
         control <= `RST_CONTROL;
         req_map <= `RST_REQ_MAP;
         cpu_cfg <= `RST_CPU_CFG;
         pci_cfg <= `RST_PCI_CFG;
      end else begin
         o_pready <= i_psel & i_penable & ~o_pready;
         if (i_psel & i_penable & ~o_pready) begin
            o_prdata <= next_rdata;
            o_pslverr <= ~(i_paddr == `ADDR_DRIVE_MODE ||
               i_paddr == `ADDR_CONTROL || i_paddr == `ADDR_REQ_MAP ||
               i_paddr == `ADDR_STATUS || i_paddr == `ADDR_CPU_CFG ||
               i_paddr == `ADDR_PCI_CFG);
         end else begin
            // Error flag stands only with its ready pulse
            o_pslverr <= 1'b0;
         end
         if (apb_access & i_pwrite) begin
            case (i_paddr)
               `ADDR_DRIVE_MODE: drive_mode <= i_pwdata[7:0];
               `ADDR_CONTROL: control <= i_pwdata[7:0];
               `ADDR_REQ_MAP: req_map <= i_pwdata[7:0] & 8'h77;
               `ADDR_CPU_CFG: cpu_cfg <= i_pwdata[7:0] & 8'h07;
               `ADDR_PCI_CFG: pci_cfg <= i_pwdata[7:0] & 8'h01;
               default: req_map <= req_map;
            endcase
         end
      end
   end

   // Power sequencing
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_WAIT_PG;
         park_cnt <= 3'd0;
         lock_cnt <= 32'd0;
         locked <= 1'b0;
         tri_cnt <= 32'd0;
         tri_hold <= 1'b0;
         o_osc_enable <= 1'b1;
         o_clocks_stable <= 1'b0;
      end else begin
         case (state)
            ST_WAIT_PG: begin
               // Pin low means power good; pin turns into power-down
               if (!pin_level)
                  state <= ST_RUN;
            end
            ST_RUN: begin
               if (pin_level) begin
                  state <= ST_PARK;
                  park_cnt <= 3'd0;
               end
            end
            ST_PARK: begin
               // Park on a complement fall, forced by the 4-cycle bound
               park_cnt <= park_cnt + 3'd1;
               if (diff_fall || park_cnt == `PARK_DELAY_CYC - 1)
                  state <= ST_DOWN;
            end
            ST_DOWN: begin
               // Oscillator off only once outputs are parked
               o_osc_enable <= 1'b0;
               if (!pin_level) begin
                  state <= ST_RUN;
                  o_osc_enable <= 1'b1;
                  tri_hold <= 1'b1;
                  tri_cnt <= 32'd0;
               end
            end
            default: state <= ST_WAIT_PG;
         endcase
         if (state == ST_RUN && o_osc_enable) begin
            // Lock wait bounds the power-up latency
            if (!locked) begin
               lock_cnt <= lock_cnt + 32'd1;
               if (lock_cnt >= LOCK_CYCLES - 1)
                  locked <= 1'b1;
            end
         end else begin
            lock_cnt <= 32'd0;
            locked <= 1'b0;
         end
         if (tri_hold) begin
            tri_cnt <= tri_cnt + 32'd1;
            if (tri_cnt >= TRI_REL_CYCLES - 1 || locked)
               tri_hold <= 1'b0;
         end
         // Stable flag follows powered one cycle late; outputs gate on powered directly, SRC and CPU true legs earlier under tri_hold
         o_clocks_stable <= powered;
      end
   end

   // Stop state machines, changed only on clock falls so pulses stay whole
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         diff_d <= 1'b0;
         pci_d <= 1'b0;
         src_stopped <= 6'h00;
         cpu_stopped <= 3'h0;
         pci_stopped <= 1'b0;
         cpu_wait <= 2'd0;
      end else begin
         diff_d <= i_diff_clock_complement;
         pci_d <= i_pci_raw;
         if (diff_fall) begin
            // SRC stops on the next fall, CPU on the third; CPU pairs restart together
            src_stopped <= src_req | ({6{pci_stop}} &
               {6{~drive_mode[7]}});
            if (~cpu_stop_n) begin
               if (cpu_wait != `STOP_DELAY_CYC)
                  cpu_wait <= cpu_wait + 2'd1;
               else
                  cpu_stopped <= cpu_cfg[2:0];
            end else begin
               cpu_wait <= 2'd0;
               cpu_stopped <= 3'h0;
            end
         end
         if (pci_fall) begin
            // Stop and resume on a PCI fall keeps pulses whole
            pci_stopped <= pci_stop;
         end
      end
   end

   // Output drivers
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_src
         always @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_serial_ref_clock_true[g] <= 1'b0;
               o_serial_ref_clock_comp[g] <= 1'b0;
               o_src_true_oe[g] <= 1'b0;
               o_src_comp_oe[g] <= 1'b0;
            end else if (state == ST_DOWN || state == ST_PARK) begin
               // Mode 0 true high, 1 both off
               o_serial_ref_clock_true[g] <= 1'b1;
               o_serial_ref_clock_comp[g] <= 1'b0;
               o_src_true_oe[g] <= ~drive_mode[`BIT_SRC_PD_MODE];
               o_src_comp_oe[g] <= 1'b0;
            end else if (tri_hold) begin
               o_serial_ref_clock_true[g] <= 1'b1;
               o_serial_ref_clock_comp[g] <= 1'b0;
               o_src_true_oe[g] <= 1'b1;
               o_src_comp_oe[g] <= 1'b0;
            end else if (src_stopped[g] || !powered) begin
               o_serial_ref_clock_true[g] <= 1'b0;
               o_serial_ref_clock_comp[g] <= 1'b0;
               o_src_true_oe[g] <= 1'b0;
               o_src_comp_oe[g] <= 1'b0;
            end else begin
               o_serial_ref_clock_true[g] <= ~i_diff_clock_complement;
               o_serial_ref_clock_comp[g] <= i_diff_clock_complement;
               o_src_true_oe[g] <= 1'b1;
               o_src_comp_oe[g] <= 1'b1;
            end
         end
      end
      for (g = 0; g < 3; g = g + 1) begin : g_cpu
         always @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_cpu_clock_true[g] <= 1'b0;
               o_cpu_clock_comp[g] <= 1'b0;
               o_cpu_true_oe[g] <= 1'b0;
               o_cpu_comp_oe[g] <= 1'b0;
            end else if (state == ST_DOWN || state == ST_PARK) begin
               o_cpu_clock_true[g] <= 1'b1;
               o_cpu_clock_comp[g] <= 1'b0;
               o_cpu_true_oe[g] <= ~drive_mode[g];
               o_cpu_comp_oe[g] <= 1'b0;
            end else if (cpu_stopped[g] || tri_hold) begin
               // Same drive, true high, complement off
               o_cpu_clock_true[g] <= 1'b1;
               o_cpu_clock_comp[g] <= 1'b0;
               o_cpu_true_oe[g] <= 1'b1;
               o_cpu_comp_oe[g] <= 1'b0;
            end else begin
               o_cpu_clock_true[g] <= powered & ~i_diff_clock_complement;
               o_cpu_clock_comp[g] <= powered & i_diff_clock_complement;
               o_cpu_true_oe[g] <= powered;
               o_cpu_comp_oe[g] <= powered;
            end
         end
      end
   endgenerate

   // Single-ended outputs freeze low in power-down
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pci_clk <= 1'b0;
         o_free_pci_clock <= 1'b0;
      end else begin
         o_pci_clk <= powered & ~pci_stopped & i_pci_raw;
         o_free_pci_clock <= powered & i_pci_raw &
            (pci_cfg[0] | ~pci_stopped);
      end
   end
endmodule // clock_output_stop_power_down_control

// *** test/clock_output_stop_power_down_control_sva.sv ***
`timescale 1ns/100ps
module clock_output_stop_power_down_control_sva #(
   parameter LOCK_CYCLES = 20,
   parameter TRI_REL_CYCLES = 10
) (
   // Clock, reset and bus
   input wire i_ref_clk,
   input wire i_arst_n,
   input wire i_psel,
   input wire i_penable,
   input wire o_pready,
   input wire o_pslverr,
   // Stop inputs
   input wire i_cpu_clock_stop_n,
   input wire i_pci_clock_stop_n,
   // Watched outputs
   input wire [5:0] o_src_true_oe,
   input wire [5:0] o_src_comp_oe,
   input wire [2:0] o_cpu_true_oe,
   input wire [2:0] o_cpu_comp_oe,
   input wire o_pci_clk,
   input wire o_free_pci_clock,
   input wire o_osc_enable,
   input wire o_clocks_stable
);
   reg [5:0] cpu_cnt;
   reg [5:0] pci_cnt;
   reg [31:0] wait_cnt;
   // Hold counts saturate well past the sync, debounce and three-fall stop
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cpu_cnt <= 6'h00;
         pci_cnt <= 6'h00;
         wait_cnt <= 32'h0;
      end else begin
         cpu_cnt <= i_cpu_clock_stop_n ? 6'h00 : cpu_cnt + (cpu_cnt != 6'h30);
         pci_cnt <= i_pci_clock_stop_n ? 6'h00 : pci_cnt + (pci_cnt != 6'h30);
         wait_cnt <= (o_osc_enable && !o_clocks_stable) ? wait_cnt + 1 : 32'h0;
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   pready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("pready stood longer than one cycle");
   pready_access_a: assert property (o_pready |-> i_psel && i_penable)
      else $error("pready outside an access");
   slverr_qual_a: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   src_comp_alone_a: assert property (
      (o_src_comp_oe & ~o_src_true_oe) == 6'h00)
      else $error("SRC complement driven alone");
   cpu_comp_alone_a: assert property (
      (o_cpu_comp_oe & ~o_cpu_true_oe) == 3'h0)
      else $error("CPU complement driven alone");
   osc_off_low_a: assert property (
      !o_osc_enable |-> !o_pci_clk && !o_free_pci_clock && !o_clocks_stable)
      else $error("clock active with oscillator off");
   pci_stop_low_a: assert property (pci_cnt == 6'h30 |-> !o_pci_clk)
      else $error("PCI clock high under stop");
   cpu_stop_park_a: assert property (
      cpu_cnt == 6'h30 |-> o_cpu_comp_oe == 3'h0)
      else $error("CPU complement driven under stop");
   lock_bound_a: assert property (wait_cnt <= LOCK_CYCLES + 32)
      else $error("clocks not stable in time");
endmodule // clock_output_stop_power_down_control_sva

// *** test/platform_model.sv ***
`timescale 1ns/100ps
module platform_model (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_arst_n,
   // Requests from the bench, and the generator's oscillator enable
   input wire [1:0] i_req_cmd_n,
   input wire i_cpu_cmd_n,
   input wire i_pci_cmd_n,
   input wire i_down_cmd,
   input wire i_osc_enable,
   // Pins toward the generator
   output reg [1:0] o_src_clock_request_n,
   output reg o_cpu_clock_stop_n,
   output reg o_pci_clock_stop_n,
   output reg o_power_good_n,
   output wire o_diff_clock_complement,
   output wire o_pci_raw
);
   reg [2:0] phase;
   reg good_seen;
   // Raw clocks freeze while the oscillator is off, as real ones would
   assign o_diff_clock_complement = phase[1];
   assign o_pci_raw = phase[2];
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase <= 3'h0;
         good_seen <= 1'b0;
         o_src_clock_request_n <= 2'h3;
         o_cpu_clock_stop_n <= 1'b1;
         o_pci_clock_stop_n <= 1'b1;
         o_power_good_n <= 1'b1;
      end else begin
         if (i_osc_enable)
            phase <= phase + 3'h1;
         o_src_clock_request_n <= i_req_cmd_n;
         o_cpu_clock_stop_n <= i_cpu_cmd_n;
         o_pci_clock_stop_n <= i_pci_cmd_n;
         good_seen <= 1'b1;
         // Power good first; power-down may follow one cycle later
         o_power_good_n <= good_seen & i_down_cmd;
      end
   end
endmodule // platform_model

// *** test/clock_output_stop_power_down_control_tb.sv ***
`timescale 1ns/100ps
module clock_output_stop_power_down_control_tb;
   localparam LOCK = 20;
   localparam TRI = 10;
   reg i_ref_clk = 1'b0;
   reg i_arst_n = 1'b0;
   reg i_psel = 1'b0;
   reg i_penable = 1'b0;
   reg i_pwrite = 1'b0;
   reg [11:0] i_paddr = 12'h000;
   reg [31:0] i_pwdata = 32'h0;
   reg [1:0] req_n = 2'h0;
   reg cpu_n = 1'b1;
   reg pci_n = 1'b1;
   reg down = 1'b0;
   wire [31:0] o_prdata;
   wire o_pready, o_pslverr, i_cpu_clock_stop_n, i_pci_clock_stop_n;
   wire [1:0] i_src_clock_request_n;
   wire i_power_good_n, i_diff_clock_complement, i_pci_raw;
   wire [5:0] o_serial_ref_clock_true, o_serial_ref_clock_comp;
   wire [5:0] o_src_true_oe, o_src_comp_oe;
   wire [2:0] o_cpu_clock_true, o_cpu_clock_comp, o_cpu_true_oe, o_cpu_comp_oe;
   wire o_pci_clk, o_free_pci_clock, o_osc_enable, o_clocks_stable;
   integer error_cnt = 0;
   integer total_checks = 0;
   integer cyc = 0;
   integer n;
   integer i;
   logic [31:0] rd;
   logic er;
   // Rows: write, address, write data, expected read byte, expected error
   reg [53:0] rows [0:12] = '{
      {1'b0, 12'h014, 32'h0, 8'h00, 1'b0}, {1'b0, 12'h018, 32'h0, 8'h18, 1'b0},
      {1'b0, 12'h020, 32'h0, 8'h44, 1'b0}, {1'b0, 12'h028, 32'h0, 8'h07, 1'b0},
      {1'b0, 12'h02C, 32'h0, 8'h00, 1'b0}, {1'b0, 12'h030, 32'h0, 8'h00, 1'b1},
      {1'b1, 12'h030, 32'hFF, 8'h00, 1'b1}, {1'b0, 12'h030, 32'h0, 8'h00, 1'b1},
      {1'b1, 12'h014, 32'hFFFFFF08, 8'h00, 1'b0},
      {1'b0, 12'h014, 32'h0, 8'h08, 1'b0}, {1'b1, 12'h014, 32'h0, 8'h00, 1'b0},
      {1'b1, 12'h018, 32'h18, 8'h00, 1'b0}, {1'b0, 12'h018, 32'h0, 8'h18, 1'b0}};

   clock_output_stop_power_down_control #(
      .LOCK_CYCLES(LOCK),
      .TRI_REL_CYCLES(TRI)
   ) dut (.i_ref_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_src_clock_request_n,
      .i_cpu_clock_stop_n, .i_pci_clock_stop_n, .i_power_good_n,
      .i_diff_clock_complement, .i_pci_raw, .o_serial_ref_clock_true,
      .o_serial_ref_clock_comp, .o_src_true_oe, .o_src_comp_oe,
      .o_cpu_clock_true, .o_cpu_clock_comp, .o_cpu_true_oe, .o_cpu_comp_oe,
      .o_pci_clk, .o_free_pci_clock, .o_osc_enable, .o_clocks_stable);

   platform_model far (.i_ref_clk, .i_arst_n, .i_req_cmd_n(req_n),
      .i_cpu_cmd_n(cpu_n), .i_pci_cmd_n(pci_n), .i_down_cmd(down),
      .i_osc_enable(o_osc_enable), .o_src_clock_request_n(i_src_clock_request_n),
      .o_cpu_clock_stop_n(i_cpu_clock_stop_n),
      .o_pci_clock_stop_n(i_pci_clock_stop_n), .o_power_good_n(i_power_good_n),
      .o_diff_clock_complement(i_diff_clock_complement), .o_pci_raw(i_pci_raw));

   initial begin
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: register got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_pin(input logic [7:0] got, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: pins got %h expected %h", $time, got, exp);
      end
   endtask

   function logic cond(input integer s);
      case (s)
         0: cond = o_clocks_stable === 1'b1;
         1: cond = o_osc_enable === 1'b0;
         2: cond = (o_src_true_oe[0] | o_src_true_oe[4]) === 1'b1;
         3: cond = o_cpu_comp_oe === 3'h0;
         4: cond = o_cpu_comp_oe === 3'h7;
         5: cond = o_pci_clk === 1'b1;
         6: cond = o_cpu_true_oe === 3'h7;
         7: cond = (o_src_true_oe[0] | o_src_true_oe[4]) === 1'b0;
         default: cond = o_free_pci_clock === 1'b1;
      endcase
   endfunction

   // Bounded wait; running out of cycles counts as a mismatch
   task wait_on(input integer s, input integer lim);
      n = 0;
      while (!cond(s) && n < lim) begin
         @(posedge i_ref_clk);
         n = n + 1;
      end
      chk_pin({7'h00, n < lim}, 8'h01);
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n = n + 1;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20)
         chk_pin(8'h00, 8'h01);
   endtask

   task final_report;
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         final_report;
      end
   end

   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      wait_on(0, LOCK + 40);
      for (i = 0; i < 13; i = i + 1) begin
         apb(rows[i][53], rows[i][52:41], rows[i][40:9]);
         chk_reg({31'h0, er}, {31'h0, rows[i][0]});
         if (!rows[i][53])
            chk_reg(rd, {24'h0, rows[i][8:1]});
      end
      $display("Test registers done");
      apb(1'b1, 12'h020, 32'h45);
      req_n <= 2'b01;
      wait_on(7, 60);
      chk_pin({3'h0, o_serial_ref_clock_comp[0], o_src_comp_oe[4],
         o_src_comp_oe[0], o_src_true_oe[2], o_serial_ref_clock_true[0]},
         8'h02);
      req_n <= 2'b00;
      wait_on(2, 40);
      chk_pin({6'h00, o_src_true_oe[4], o_src_true_oe[0]}, 8'h03);
      $display("Test request done");
      cpu_n <= 1'b0;
      wait_on(3, 48);
      chk_pin({o_cpu_clock_comp[1:0], o_cpu_clock_true, o_cpu_true_oe},
         8'h3F);
      // Hold the stop long enough for the checker's settled-stop window
      repeat (40) @(posedge i_ref_clk);
      cpu_n <= 1'b1;
      wait_on(4, 20);
      $display("Test cpu stop done");
      pci_n <= 1'b0;
      repeat (56) @(posedge i_ref_clk);
      chk_pin({6'h00, o_pci_clk, o_free_pci_clock}, 8'h00);
      pci_n <= 1'b1;
      wait_on(5, 32);
      apb(1'b1, 12'h02C, 32'h1);
      pci_n <= 1'b0;
      repeat (40) @(posedge i_ref_clk);
      wait_on(8, 16);
      chk_pin({7'h00, o_pci_clk}, 8'h00);
      pci_n <= 1'b1;
      apb(1'b1, 12'h018, 32'h10);
      repeat (40) @(posedge i_ref_clk);
      chk_pin({7'h00, o_pci_clk}, 8'h00);
      apb(1'b1, 12'h018, 32'h18);
      wait_on(5, 32);
      $display("Test pci stop done");
      for (i = 0; i < 2; i = i + 1) begin
         apb(1'b1, 12'h014, i ? 32'h0F : 32'h00);
         down <= 1'b1;
         wait_on(1, 40);
         chk_pin({o_pci_clk, o_free_pci_clock, o_cpu_true_oe, o_cpu_comp_oe},
            i ? 8'h00 : 8'h38);
         down <= 1'b0;
         wait_on(6, TRI + 12);
         wait_on(0, LOCK + TRI + 40);
         chk_pin({o_cpu_comp_oe, o_src_comp_oe[4:0]}, 8'hFF);
      end
      $display("Test power-down done");
      i_arst_n <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      chk_pin({o_osc_enable, o_pready, o_pci_clk, o_clocks_stable,
         o_src_true_oe[3:0]}, 8'h80);
      i_arst_n <= 1'b1;
      wait_on(0, LOCK + 40);
      $display("Test reset done");
      final_report;
   end
endmodule // clock_output_stop_power_down_control_tb

bind clock_output_stop_power_down_control
   clock_output_stop_power_down_control_sva #(
      .LOCK_CYCLES(LOCK_CYCLES),
      .TRI_REL_CYCLES(TRI_REL_CYCLES)
   ) sva (.i_ref_clk, .i_arst_n, .i_psel, .i_penable, .o_pready, .o_pslverr,
      .i_cpu_clock_stop_n, .i_pci_clock_stop_n, .o_src_true_oe,
      .o_src_comp_oe, .o_cpu_true_oe, .o_cpu_comp_oe, .o_pci_clk,
      .o_free_pci_clock, .o_osc_enable, .o_clocks_stable);
